// file: pfsw_buf.sv
// Four-word program buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module pfsw_buf
	import pfsw_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// Write side
	input  wire logic              we_i,
	input  wire logic [1:0]        waddr_i,
	input  wire logic [WORD_W-1:0] wdata_i,
	// Read side
	input  wire logic [1:0]        raddr_i,
	output logic      [WORD_W-1:0] rdata_o
);
	logic [WORD_W-1:0] mem [4];

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < 4; i++) begin
				mem[i] <= '0;
			end
			rdata_o <= '0;
		end else begin
			if (we_i) begin
				mem[waddr_i] <= wdata_i;
			end
			rdata_o <= mem[raddr_i];
		end
	end
endmodule : pfsw_buf
`default_nettype wire

// file: pfsw_ctrl.sv
// Flash self-write controller: registers, read sequencing, buffered block writes
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Calibration select steers reads to test area when set, user area otherwise.
// - Write allow bit permits write cycles; clear blocks every write.
// - Write go starts a write; hardware clears it, software zero ignored.
// - Read go starts a one-cycle read; only hardware clears it.
// - Read uses second cycle after go; that instruction dropped; data next cycle.
// - Data registers hold last read until next read or software write.
// - Self-write lands only in segments left unprotected by protection config.
// - Writes work on aligned four-word blocks, never crossing a boundary.
// - First three words of a block only fill the buffer, no stall.
// - Last word of block programs the buffer, erasing the 16-word row first only for the row's first block.
// - Row erase only when low address matches xxxx0011.
// - Two setup cycles after write go; software follows with two no-ops.
// - Core halts about 4 ms during program; clocks keep running.
// - Execution resumes at third instruction after the write go.
// - Write allow cleared at power-up; writes blocked during 72 ms timer.
// - Under code lock core still reads and writes; test access disabled.
// - Protected regions readable; self-write blocked; external programmer unaffected.
// - Code lock refuses writes from the external serial programmer.
// - Writes attempted with calibration select set are suppressed.
// - Unlock port stores nothing and reads as zero.
// - Word is 14 bits; high data register upper two bits read zero.
module pfsw_ctrl
	import pfsw_pkg::*;
#(
	parameter int HALT_CYCLES  = HALT_CYC,
	parameter int PWRUP_CYCLES = PWRUP_CYC
)
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// Register port
	input  wire logic [2:0]        reg_addr_i,
	input  wire logic [7:0]        reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [7:0]        reg_rdata_o,
	// Core sequencing
	input  wire logic              instr_cycle_i,
	output logic                   instr_discard_o,
	output logic                   core_halt_signal_o,
	// Protection configuration
	input  wire logic [1:0]        self_protect_cfg_i,
	input  wire logic              code_lock_bit_i,
	input  wire logic              serial_prog_mode_i,
	input  wire logic              serial_prog_wr_i,
	output logic                   serial_prog_wr_ok_o,
	// Flash array
	output logic      [ADDR_W-1:0] fl_addr_o,
	output logic                   fl_test_sel_o,
	output logic                   fl_rd_o,
	input  wire logic [WORD_W-1:0] fl_rdata_i,
	output logic                   fl_erase_o,
	output logic                   fl_prog_o,
	output logic      [WORD_W-1:0] fl_wdata_o
);
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_SETUP = 5'b00010,
		ST_ERASE = 5'b00100,
		ST_PROG  = 5'b01000,
		ST_NEXT  = 5'b10000
	} pfsw_state_t;

	// Protected segment test: upper address quarter index vs config level
	function automatic logic seg_protected(input logic [ADDR_W-1:0] a, input logic [1:0] cfg);
		logic [1:0] q;
		q = a[ADDR_W-1 -: 2];
		case (cfg)
			2'h0:    seg_protected = 1'b1;
			2'h1:    seg_protected = (q != 2'h3);
			2'h2:    seg_protected = (q == 2'h0);
			default: seg_protected = 1'b0;
		endcase
	endfunction : seg_protected

	pfsw_state_t       state;
	pfsw_state_t       next_state;
	logic              calib_space_select;
	logic              flash_write_allow;
	logic              wgo;
	logic              rgo;
	logic [7:0]        flash_addr_low;
	logic [3:0]        flash_addr_high;
	logic [7:0]        flash_data_low;
	logic [5:0]        flash_data_high;
	logic [1:0]        unlock_st;
	logic [1:0]        rd_cnt;
	logic              rd_capture;
	logic [1:0]        setup_cnt;
	logic [1:0]        pidx;
	logic              pwrup_done;
	logic [31:0]       pwrup_cnt;
	logic              erase_pend;
	logic [ADDR_W-1:0] blk_base;

	wire [ADDR_W-1:0] cur_addr   = {flash_addr_high, flash_addr_low};
	wire              wr_ctl     = reg_wr_i && (reg_addr_i == OFS_CONTROL);
	wire              wr_unlock  = reg_wr_i && (reg_addr_i == OFS_UNLOCK);
	wire              go_req     = wr_ctl && reg_wdata_i[BIT_WGO] && !wgo;
	wire              unlocked   = (unlock_st == 2'h2);
	// Allow and calibration select are judged from the same control write that sets go
	wire              wr_block   = !reg_wdata_i[BIT_WALLOW] || !pwrup_done || reg_wdata_i[BIT_CALIB_SPACE_SELECT]
	                               || seg_protected(cur_addr, self_protect_cfg_i);
	wire              go_accept  = go_req && unlocked && reg_wdata_i[BIT_WALLOW] && (state == ST_IDLE);
	wire              go_effect  = go_accept && !wr_block;
	wire              last_word  = (flash_addr_low[1:0] == LAST_IN_BLOCK);
	wire              row_start  = (flash_addr_low[3:2] == ROW_FIRST_BLK);
	wire              rd_start   = wr_ctl && reg_wdata_i[BIT_RGO] && !rgo && (state == ST_IDLE);
	wire [WORD_W-1:0] buf_wdata  = {flash_data_high, flash_data_low};
	wire              buf_we     = go_effect;
	wire              tmr_load;
	wire              tmr_busy;
	wire              tmr_done;
	wire [WORD_W-1:0] buf_rdata;

	// Block writes go to the array one cycle after the buffer word is addressed
	assign tmr_load            = (state == ST_SETUP) && (setup_cnt == 2'(SETUP_CYC - 1));
	assign core_halt_signal_o  = (state != ST_IDLE);
	assign instr_discard_o     = (rd_cnt == 2'h2) && instr_cycle_i;
	assign fl_rd_o             = instr_discard_o;
	assign fl_test_sel_o       = calib_space_select && !code_lock_bit_i;
	assign fl_addr_o           = (state == ST_IDLE) ? cur_addr : (blk_base | ADDR_W'(pidx));
	assign fl_erase_o          = (state == ST_ERASE) && tmr_done && erase_pend;
	assign fl_prog_o           = (state == ST_NEXT);
	assign fl_wdata_o          = buf_rdata;
	assign serial_prog_wr_ok_o = serial_prog_mode_i && serial_prog_wr_i && !code_lock_bit_i;

	pfsw_buf u_buf (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.we_i    (buf_we),
		.waddr_i (flash_addr_low[1:0]),
		.wdata_i (buf_wdata),
		.raddr_i (pidx),
		.rdata_o (buf_rdata)
	);

	pfsw_timer u_tmr (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.load_i  (tmr_load || ((state == ST_ERASE) && tmr_done)),
		.count_i (32'(HALT_CYCLES / 2)),
		.busy_o  (tmr_busy),
		.done_o  (tmr_done)
	);

	// Erase and program sequence
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE:  next_state = (go_effect && last_word) ? ST_SETUP : ST_IDLE;
			ST_SETUP: next_state = tmr_load ? ST_ERASE : ST_SETUP;
			ST_ERASE: next_state = tmr_done ? ST_PROG : ST_ERASE;
			ST_PROG:  next_state = (tmr_done || !tmr_busy) ? ST_NEXT : ST_PROG;
			ST_NEXT:  next_state = (pidx == 2'h3) ? ST_IDLE : ST_PROG;
			default:  next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Sequence counters and erase decision
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			setup_cnt  <= 2'h0;
			pidx       <= 2'h0;
			erase_pend <= 1'b0;
			blk_base   <= '0;
		end else begin
			if (state == ST_IDLE && go_effect && last_word) begin
				setup_cnt  <= 2'h0;
				pidx       <= 2'h0;
				erase_pend <= row_start;
				blk_base   <= {cur_addr[ADDR_W-1:2], 2'h0};
			end else if (state == ST_SETUP) begin
				setup_cnt <= setup_cnt + 2'h1;
			end else if (state == ST_NEXT) begin
				pidx <= pidx + 2'h1;
			end
		end
	end

	// Unlock sequence tracker; any other register write breaks the pair
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			unlock_st <= 2'h0;
		end else if (wr_unlock) begin
			if (reg_wdata_i == UNLOCK_FIRST) begin
				unlock_st <= 2'h1;
			end else if (reg_wdata_i == UNLOCK_SECOND && unlock_st == 2'h1) begin
				unlock_st <= 2'h2;
			end else begin
				unlock_st <= 2'h0;
			end
		end else if (reg_wr_i) begin
			unlock_st <= 2'h0;
		end
	end

	// Power-up timer
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pwrup_cnt  <= 32'h0;
			pwrup_done <= 1'b0;
		end else if (!pwrup_done) begin
			pwrup_cnt  <= pwrup_cnt + 32'h1;
			pwrup_done <= (pwrup_cnt >= 32'(PWRUP_CYCLES - 1));
		end
	end

	// Read sequencing: count instruction cycles after read go
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rd_cnt     <= 2'h0;
			rd_capture <= 1'b0;
		end else begin
			rd_capture <= instr_discard_o;
			if (rd_start) begin
				rd_cnt <= 2'h1;
			end else if (rd_cnt != 2'h0 && instr_cycle_i) begin
				rd_cnt <= (rd_cnt == 2'h2) ? 2'h0 : rd_cnt + 2'h1;
			end
		end
	end

	// Control register
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			calib_space_select <= 1'b0;
			flash_write_allow  <= 1'b0;
			wgo                <= 1'b0;
			rgo                <= 1'b0;
		end else begin
			if (wr_ctl) begin
				calib_space_select <= reg_wdata_i[BIT_CALIB_SPACE_SELECT];
				flash_write_allow  <= reg_wdata_i[BIT_WALLOW];
			end
			if (go_effect && last_word) begin
				wgo <= 1'b1;
			end else if (state == ST_NEXT && pidx == 2'h3) begin
				wgo <= 1'b0;
			end
			if (rd_start) begin
				rgo <= 1'b1;
			end else if (rd_capture) begin
				rgo <= 1'b0;
			end
		end
	end

	// Address and data registers
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			flash_addr_low  <= RST_BYTE;
			flash_addr_high <= 4'h0;
			flash_data_low  <= RST_BYTE;
			flash_data_high <= 6'h00;
		end else begin
			if (reg_wr_i && reg_addr_i == OFS_ADDR_LOW) begin
				flash_addr_low <= reg_wdata_i;
			end
			if (reg_wr_i && reg_addr_i == OFS_ADDR_HIGH) begin
				flash_addr_high <= reg_wdata_i[3:0];
			end
			if (rd_capture) begin
				flash_data_low  <= fl_rdata_i[7:0];
				flash_data_high <= fl_rdata_i[WORD_W-1:8];
			end else begin
				if (reg_wr_i && reg_addr_i == OFS_DATA_LOW) begin
					flash_data_low <= reg_wdata_i;
				end
				if (reg_wr_i && reg_addr_i == OFS_DATA_HIGH) begin
					flash_data_high <= reg_wdata_i[5:0];
				end
			end
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= RST_BYTE;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				OFS_CONTROL:   reg_rdata_o <= {1'b0, calib_space_select, 3'h0, flash_write_allow, wgo, rgo};
				OFS_UNLOCK:    reg_rdata_o <= RST_BYTE;
				OFS_ADDR_LOW:  reg_rdata_o <= flash_addr_low;
				OFS_ADDR_HIGH: reg_rdata_o <= {4'h0, flash_addr_high};
				OFS_DATA_LOW:  reg_rdata_o <= flash_data_low;
				OFS_DATA_HIGH: reg_rdata_o <= {2'h0, flash_data_high};
				default:       reg_rdata_o <= RST_BYTE;
			endcase
		end else begin
			reg_rdata_o <= RST_BYTE;
		end
	end
endmodule : pfsw_ctrl
`default_nettype wire

// file: pfsw_ctrl_props.sv
// Port-level checker for the flash self-write controller
`timescale 1ns/1ps
`default_nettype none
module pfsw_ctrl_chk
	import pfsw_pkg::*;
#(
	parameter int HALT_CYCLES  = 20,
	parameter int PWRUP_CYCLES = 10
)
(
	// Watched ports
	input wire logic       clk_i,
	input wire logic       rst_b_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       instr_cycle_i,
	input wire logic       instr_discard_o,
	input wire logic       core_halt_signal_o,
	input wire logic       code_lock_bit_i,
	input wire logic       serial_prog_mode_i,
	input wire logic       serial_prog_wr_i,
	input wire logic       serial_prog_wr_ok_o,
	input wire logic       fl_test_sel_o,
	input wire logic       fl_rd_o,
	input wire logic       fl_erase_o,
	input wire logic       fl_prog_o
);
	logic [31:0] up_cnt;
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) up_cnt <= 32'h0;
		else if (up_cnt < PWRUP_CYCLES) up_cnt <= up_cnt + 32'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence halt_start; $rose(core_halt_signal_o); endsequence
	sequence halt_run; core_halt_signal_o [*8]; endsequence
	halt_cause_a: assert property (halt_start |-> $past(reg_wr_i) && $past(reg_addr_i) == OFS_CONTROL)
		else $error("halt without a control write");
	halt_hold_a: assert property (halt_start |-> halt_run)
		else $error("halt shorter than setup and erase");
	halt_end_a: assert property (halt_start |-> ##[1:300] !core_halt_signal_o)
		else $error("halt never released");
	erase_halted_a: assert property (fl_erase_o || fl_prog_o |-> core_halt_signal_o)
		else $error("array strobe outside halt");
	read_slot_a: assert property (fl_rd_o |-> instr_cycle_i && instr_discard_o)
		else $error("read not on a discarded cycle");
	unlock_zero_a: assert property (reg_rd_i && reg_addr_i == OFS_UNLOCK |=> reg_rdata_o == 8'h00)
		else $error("unlock port read not zero");
	high_pad_a: assert property (reg_rd_i && reg_addr_i == OFS_DATA_HIGH |=> reg_rdata_o[7:6] == 2'h0)
		else $error("data high pad bits set");
	rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data without read strobe");
	serial_gate_a: assert property (serial_prog_wr_ok_o == (serial_prog_mode_i && serial_prog_wr_i && !code_lock_bit_i))
		else $error("serial write gate wrong");
	test_lock_a: assert property (code_lock_bit_i |-> !fl_test_sel_o)
		else $error("test area reachable under lock");
	pwrup_block_a: assert property (up_cnt < PWRUP_CYCLES |-> !core_halt_signal_o)
		else $error("write during power-up");
endmodule : pfsw_ctrl_chk
bind pfsw_ctrl pfsw_ctrl_chk #(.HALT_CYCLES(HALT_CYCLES), .PWRUP_CYCLES(PWRUP_CYCLES)) i_pfsw_ctrl_chk (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .instr_cycle_i(instr_cycle_i), .instr_discard_o(instr_discard_o),
	.core_halt_signal_o(core_halt_signal_o), .code_lock_bit_i(code_lock_bit_i),
	.serial_prog_mode_i(serial_prog_mode_i), .serial_prog_wr_i(serial_prog_wr_i),
	.serial_prog_wr_ok_o(serial_prog_wr_ok_o), .fl_test_sel_o(fl_test_sel_o), .fl_rd_o(fl_rd_o),
	.fl_erase_o(fl_erase_o), .fl_prog_o(fl_prog_o));
`default_nettype wire

// file: pfsw_flash_model.sv
// Behavioural flash array answering read, erase and program strobes
`timescale 1ns/1ps
`default_nettype none
module pfsw_flash_model
	import pfsw_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic [ADDR_W-1:0] fl_addr_i,
	input  wire logic              fl_test_sel_i,
	input  wire logic              fl_rd_i,
	input  wire logic              fl_erase_i,
	input  wire logic              fl_prog_i,
	input  wire logic [WORD_W-1:0] fl_wdata_i,
	output logic      [WORD_W-1:0] fl_rdata_o
);
	logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic              held;
	initial begin
		fl_rdata_o = 14'h0;
		held = 1'b0;
		for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = WORD_W'(i * 7) ^ 14'h1555;
	end
	always @(posedge clk_i) begin
		held <= fl_rd_i;
		// Data holds one cycle after a read, then wanders so stale samples show
		if (fl_rd_i) fl_rdata_o <= fl_test_sel_i ? ~mem[fl_addr_i] : mem[fl_addr_i];
		else if (!held) fl_rdata_o <= ~fl_rdata_o;
		if (fl_erase_i) for (int i = 0; i < 16; i++) mem[{fl_addr_i[ADDR_W-1:4], 4'h0} + i] <= 14'h3FFF;
		if (fl_prog_i) mem[fl_addr_i] <= fl_wdata_i;
	end
endmodule : pfsw_flash_model
`default_nettype wire

// file: pfsw_pkg.sv
// Package of constants for the flash self-write controller
package pfsw_pkg;
	localparam int          ADDR_W        = 12;
	localparam int          WORD_W        = 14;
	localparam logic [2:0]  OFS_CONTROL   = 3'h0;
	localparam logic [2:0]  OFS_UNLOCK    = 3'h1;
	localparam logic [2:0]  OFS_ADDR_LOW  = 3'h2;
	localparam logic [2:0]  OFS_ADDR_HIGH = 3'h3;
	localparam logic [2:0]  OFS_DATA_LOW  = 3'h4;
	localparam logic [2:0]  OFS_DATA_HIGH = 3'h5;
	localparam int          BIT_CALIB_SPACE_SELECT    = 6;
	localparam int          BIT_WALLOW    = 2;
	localparam int          BIT_WGO       = 1;
	localparam int          BIT_RGO       = 0;
	localparam logic [7:0]  UNLOCK_FIRST  = 8'h55;
	localparam logic [7:0]  UNLOCK_SECOND = 8'hAA;
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam int          CLK_MHZ       = 250;
	localparam int          HALT_US       = 4000;
	localparam int          PWRUP_US      = 72000;
	localparam int          HALT_CYC      = HALT_US * CLK_MHZ;
	localparam int          PWRUP_CYC     = PWRUP_US * CLK_MHZ;
	localparam int          SETUP_CYC     = 2;
	localparam logic [1:0]  LAST_IN_BLOCK = 2'h3;
	localparam logic [1:0]  ROW_FIRST_BLK = 2'h0;
endpackage : pfsw_pkg

// file: pfsw_timer.sv
// Down counter producing a done pulse after a loaded count
`timescale 1ns/1ps
`default_nettype none
module pfsw_timer
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Control
	input  wire logic        load_i,
	input  wire logic [31:0] count_i,
	output logic             busy_o,
	output logic             done_o
);
	logic [31:0] cnt;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cnt    <= 32'h0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (load_i) begin
				cnt    <= count_i;
				busy_o <= 1'b1;
			end else if (busy_o) begin
				if (cnt <= 32'h1) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end else begin
					cnt <= cnt - 32'h1;
				end
			end
		end
	end
endmodule : pfsw_timer
`default_nettype wire

// file: test_program_flash_self_write_ctrl.sv
// Self-checking bench for the flash self-write controller
`timescale 1ns/1ps
`default_nettype none
module test_program_flash_self_write_ctrl
	import pfsw_pkg::*;
();
	logic        clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, instr_cycle_i = 1'b0;
	logic        code_lock_bit_i = 1'b0, serial_prog_mode_i = 1'b0, serial_prog_wr_i = 1'b0;
	logic [2:0]  reg_addr_i = 3'h0;
	logic [7:0]  reg_wdata_i = 8'h00, q;
	logic [1:0]  self_protect_cfg_i = 2'h3, ph = 2'h0;
	logic [11:0] a, base;
	logic [13:0] w, d [4];
	int          miscompares = 0, samples_checked = 0, seed = 32'h137A7E4A, n;
	wire logic [7:0]  reg_rdata_o;
	wire logic [11:0] fl_addr_o;
	wire logic [13:0] fl_rdata_i, fl_wdata_o;
	wire logic        instr_discard_o, core_halt_signal_o, serial_prog_wr_ok_o;
	wire logic        fl_test_sel_o, fl_rd_o, fl_erase_o, fl_prog_o;
	pfsw_ctrl #(.HALT_CYCLES(20), .PWRUP_CYCLES(10)) i_pfsw_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .instr_cycle_i(instr_cycle_i), .instr_discard_o(instr_discard_o),
		.core_halt_signal_o(core_halt_signal_o), .self_protect_cfg_i(self_protect_cfg_i),
		.code_lock_bit_i(code_lock_bit_i), .serial_prog_mode_i(serial_prog_mode_i),
		.serial_prog_wr_i(serial_prog_wr_i), .serial_prog_wr_ok_o(serial_prog_wr_ok_o), .fl_addr_o(fl_addr_o),
		.fl_test_sel_o(fl_test_sel_o), .fl_rd_o(fl_rd_o), .fl_rdata_i(fl_rdata_i), .fl_erase_o(fl_erase_o),
		.fl_prog_o(fl_prog_o), .fl_wdata_o(fl_wdata_o));
	pfsw_flash_model i_pfsw_flash_model (.clk_i(clk_i), .fl_addr_i(fl_addr_o), .fl_test_sel_i(fl_test_sel_o),
		.fl_rd_i(fl_rd_o), .fl_erase_i(fl_erase_o), .fl_prog_i(fl_prog_o), .fl_wdata_i(fl_wdata_o),
		.fl_rdata_o(fl_rdata_i));
	initial forever #2 clk_i = ~clk_i;
	// Instruction cycle every fourth clock; serial programmer lines wander
	always @(posedge clk_i) begin
		ph <= ph + 2'h1;
		instr_cycle_i <= (ph == 2'h3);
		serial_prog_mode_i <= 1'($random(seed));
		serial_prog_wr_i <= 1'($random(seed));
	end
	function automatic logic [13:0] uw(input logic [11:0] x);
		return 14'(x * 7) ^ 14'h1555;
	endfunction : uw
	task automatic bus(input logic wr, rd, input logic [2:0] ad, input logic [7:0] dt);
		reg_wr_i <= wr;
		reg_rd_i <= rd;
		reg_addr_i <= ad;
		reg_wdata_i <= dt;
		@(posedge clk_i);
	endtask : bus
	task automatic chk8(input logic [7:0] g, e, input string m);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk8
	task automatic rdb(input logic [2:0] ad, output logic [7:0] r);
		bus(1'b0, 1'b1, ad, 8'h00);
		#1 r = reg_rdata_o;
	endtask : rdb
	task automatic rdw(input logic [11:0] x, input logic [7:0] ctl, output logic [13:0] r);
		logic [7:0] lo, hi;
		int k;
		bus(1'b1, 1'b0, OFS_ADDR_LOW, x[7:0]);
		bus(1'b1, 1'b0, OFS_ADDR_HIGH, {4'h0, x[11:8]});
		bus(1'b1, 1'b0, OFS_CONTROL, ctl | 8'h01);
		k = 0;
		lo = 8'h01;
		while (lo[0] === 1'b1 && k < 20) begin
			rdb(OFS_CONTROL, lo);
			k++;
		end
		chk8(lo, ctl, "read go stuck");
		rdb(OFS_DATA_LOW, lo);
		rdb(OFS_DATA_HIGH, hi);
		r = {hi[5:0], lo};
	endtask : rdw
	task automatic wrw(input logic [11:0] x, input logic [13:0] v, input logic [7:0] ctl);
		bus(1'b1, 1'b0, OFS_ADDR_LOW, x[7:0]);
		bus(1'b1, 1'b0, OFS_ADDR_HIGH, {4'h0, x[11:8]});
		bus(1'b1, 1'b0, OFS_DATA_LOW, v[7:0]);
		bus(1'b1, 1'b0, OFS_DATA_HIGH, {2'h0, v[13:8]});
		bus(1'b1, 1'b0, OFS_UNLOCK, UNLOCK_FIRST);
		bus(1'b1, 1'b0, OFS_UNLOCK, UNLOCK_SECOND);
		bus(1'b1, 1'b0, OFS_CONTROL, ctl);
		bus(1'b0, 1'b0, 3'h0, 8'h00);
	endtask : wrw
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		wrw(12'h003, 14'h0, 8'h06);
		rdb(OFS_CONTROL, q); chk8(q, 8'h04, "write during power-up");
		$display("power-up test done");
		rst_b_i <= 1'b0;
		repeat (12) bus(1'b0, 1'b0, 3'h0, 8'h00);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rdb(3'(i), q); chk8(q, 8'h00, "reset value");
		end
		bus(1'b1, 1'b0, OFS_DATA_HIGH, 8'hFF);
		rdb(OFS_DATA_HIGH, q); chk8(q, 8'h3F, "data high width");
		bus(1'b1, 1'b0, OFS_ADDR_HIGH, 8'hFF);
		rdb(OFS_ADDR_HIGH, q); chk8(q, 8'h0F, "address high width");
		bus(1'b1, 1'b0, OFS_UNLOCK, UNLOCK_FIRST);
		rdb(OFS_UNLOCK, q); chk8(q, 8'h00, "unlock port stored");
		$display("register test done");
		for (int i = 0; i < 8; i++) begin
			a = (i == 0) ? 12'h000 : (i == 7) ? 12'hFFF : 12'($random(seed));
			code_lock_bit_i <= i[1];
			rdw(a, {1'b0, i[0], 6'h00}, w);
			chk8(8'(w ^ ((i[0] && !i[1]) ? ~uw(a) : uw(a))), 8'h00, "read word low");
			chk8(8'((w ^ ((i[0] && !i[1]) ? ~uw(a) : uw(a))) >> 8), 8'h00, "read word high");
		end
		code_lock_bit_i <= 1'b0;
		$display("read test done");
		bus(1'b1, 1'b0, OFS_CONTROL, 8'h06);
		rdb(OFS_CONTROL, q); chk8(q, 8'h04, "go without unlock");
		wrw(12'h013, 14'h0, 8'h02);
		rdb(OFS_CONTROL, q); chk8(q, 8'h00, "go without allow");
		wrw(12'h013, 14'h0, 8'h46);
		rdb(OFS_CONTROL, q); chk8(q, 8'h44, "go with calib select");
		self_protect_cfg_i <= 2'h0;
		wrw(12'h013, 14'h0, 8'h06);
		rdb(OFS_CONTROL, q); chk8(q, 8'h04, "go into protected area");
		self_protect_cfg_i <= 2'h3;
		$display("refusal test done");
		base = {8'($random(seed)), 4'h0};
		for (int k = 0; k < 4; k++) begin
			d[k] = 14'($random(seed));
			if (k == 1) rdw(base + 12'(k), 8'h00, d[k]);
			wrw(base + 12'(k), d[k], 8'h06);
			if (k < 3) begin
				rdb(OFS_CONTROL, q); chk8(q, 8'h04, "buffer write pending");
				chk8({7'h0, core_halt_signal_o}, 8'h00, "buffer write halted");
			end
		end
		n = 0;
		while (core_halt_signal_o === 1'b1 && n < 400) begin
			bus(1'b0, 1'b0, 3'h0, 8'h00);
			n++;
		end
		chk8({7'h0, n > 20}, 8'h01, "halt too short");
		rdb(OFS_CONTROL, q); chk8(q, 8'h04, "write go not cleared");
		for (int k = 0; k < 4; k++) begin
			rdw(base + 12'(k), 8'h00, w);
			chk8(8'(w ^ d[k]), 8'h00, "programmed low");
			chk8(8'((w ^ d[k]) >> 8), 8'h00, "programmed high");
		end
		rdw(base + 12'h5, 8'h00, w);
		chk8(8'(w >> 6), 8'hFF, "row not erased");
		$display("block write test done");
		complete_run();
	end
endmodule : test_program_flash_self_write_ctrl
`default_nettype wire
